/* File: design/dcci_pkg.sv */
// constants shared by the dma channel control and index block
package dcci_pkg;

  // *****************************************
  // register indices (byte address = 4 * index)
  // *****************************************
  localparam logic [31:0] IDX_ITEM_INDEX   = 32'h5000360E; // item index, read only
  localparam logic [31:0] IDX_SRC_LOW      = 32'h50003610; // source start, low half
  localparam logic [31:0] IDX_SRC_HIGH     = 32'h50003612; // source start, high half
  localparam logic [31:0] IDX_DST_LOW      = 32'h50003614; // destination start, low half
  localparam logic [31:0] IDX_DST_HIGH     = 32'h50003616; // destination start, high half
  localparam logic [31:0] IDX_IRQ_COUNT    = 32'h50003618; // interrupt compare count
  localparam logic [31:0] IDX_LENGTH       = 32'h5000361A; // transfer length minus one
  localparam logic [31:0] IDX_CONTROL      = 32'h5000361C; // channel control
  localparam logic [31:0] IDX_IRQ_STATUS   = 32'h5000361E; // sticky event flags
  localparam logic [31:0] IDX_IRQ_MASK     = 32'h50003620; // event mask
  localparam logic [31:0] IDX_REQ_SELECT   = 32'h50003622; // request selector

  // word index bits decoded from the wishbone address
  localparam int unsigned WORD_W = 6;

  // *****************************************
  // control register fields
  // *****************************************
  localparam int unsigned CTRL_ON_BIT    = 0;
  localparam int unsigned CTRL_WIDTH_LSB = 1;
  localparam int unsigned CTRL_IRQEN_BIT = 3;
  localparam int unsigned CTRL_TRIG_BIT  = 4;
  localparam int unsigned CTRL_DINC_BIT  = 5;
  localparam int unsigned CTRL_SINC_BIT  = 6;
  localparam int unsigned CTRL_CIRC_BIT  = 7;
  localparam int unsigned CTRL_W         = 8;

  // status / mask fields
  localparam int unsigned ST_MATCH_BIT = 0;
  localparam int unsigned ST_DONE_BIT  = 1;
  localparam int unsigned ST_W         = 2;

  // reset values
  localparam logic [15:0] RST_HALF = 16'h0000;
  localparam logic [7:0]  RST_CTRL = 8'h00;

  // item width codes
  localparam logic [1:0] WIDTH_BYTE = 2'h0;
  localparam logic [1:0] WIDTH_HALF = 2'h1;
  localparam logic [1:0] WIDTH_WORD = 2'h2;
  localparam logic [1:0] WIDTH_RSVD = 2'h3;

  // channel sequencer states
  typedef enum logic [1:0] {
    ST_IDLE     = 2'b00,
    ST_WAIT_REQ = 2'b01,
    ST_READ     = 2'b10,
    ST_WRITE    = 2'b11
  } dcci_state_type;

endpackage

/* File: design/dcci_req_sync.sv */
// two-stage synchroniser for the peripheral request lines
`timescale 1ns/100ps
module dcci_req_sync #(
  parameter int unsigned REQ_N = 16
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // asynchronous requests in, synchronised levels out
  input  wire logic [REQ_N-1:0] req_i,
  output logic      [REQ_N-1:0] req_o
);

  // *****************************************
  // per-line synchroniser
  // *****************************************
  genvar g;
  generate
    for (g = 0; g < REQ_N; g++) begin : g_line
      logic meta; // first stage, read only by the second stage
      logic held; // second stage, safe for logic
      // both stages clear on reset so no stale request survives it
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          meta <= 1'b0;
          held <= 1'b0;
        end else begin
          meta <= req_i[g];
          held <= meta;
        end
      end
      assign req_o[g] = held;
    end
  endgenerate

endmodule

/* File: design/dcci_addr_gen.sv */
// address former: start address plus scaled item index
`timescale 1ns/100ps
module dcci_addr_gen
  import dcci_pkg::*;
(
  // programmed start and progress
  input  wire logic [31:0] start_i,
  input  wire logic [15:0] index_i,
  input  wire logic [1:0]  width_i,
  input  wire logic        incr_i,
  // address of the current item
  output logic      [31:0] addr_o
);

  logic [31:0] offset; // byte offset of the current item

  // *****************************************
  // offset from index and width
  // *****************************************
  // step by width
  always_comb begin
    unique case (width_i)
      WIDTH_HALF: offset = {15'h0000, index_i, 1'b0};
      WIDTH_WORD: offset = {14'h0000, index_i, 2'b00};
      // reserved code behaves as a byte
      default:    offset = {16'h0000, index_i};
    endcase
  end

  assign addr_o = incr_i ? 32'(start_i + offset) : start_i;

endmodule

/* File: design/dcci_channel.sv */
// one dma channel: control, index, addresses, interrupt and sequencer
//
// Overview of operation
// - mode 0 starts moving once switched on
// - mode 1 moves only on selected request
// - interrupt enable bit gates count interrupt
// - width code picks 1, 2, 4 byte items
// - channel off means inactive, no activity once the item in flight is written
// - on bit self-clears at end unless circular in mode 1
// - item index is read only progress count
// - index returns to zero at completion
// - addresses formed from index, increments, width
// - source start held as two 16-bit halves
// - destination start held as two halves
// - count match after item raises interrupt
// - length N moves N+1 items
// - enabled increment steps 1, 2 or 4
// - circular peripheral mode clears index, restarts
`timescale 1ns/100ps
module dcci_channel
  import dcci_pkg::*;
#(
  parameter int unsigned REQ_N = 16 // peripheral request lines
) (
  // clock and reset
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // wishbone register slave
  input  wire logic             cyc_i,
  input  wire logic             stb_i,
  input  wire logic             we_i,
  input  wire logic [7:0]       adr_i,
  input  wire logic [3:0]       sel_i,
  input  wire logic [31:0]      dat_i,
  output logic      [31:0]      dat_o,
  output logic                  ack_o,
  // peripheral requests
  input  wire logic [REQ_N-1:0] periph_req_i,
  // system bus master for data moves
  output logic                  mem_cyc_o,
  output logic                  mem_we_o,
  output logic      [31:0]      mem_addr_o,
  output logic      [1:0]       mem_size_o,
  output logic      [31:0]      mem_wdata_o,
  input  wire logic [31:0]      mem_rdata_i,
  input  wire logic             mem_ack_i,
  // interrupt
  output logic                  irq_o
);

  // *****************************************
  // parameter check
  // *****************************************
  if (REQ_N < 1 || REQ_N > 16) begin : g_bad_req_n
    $error("REQ_N must be between 1 and 16");
  end

  // *****************************************
  // declarations
  // *****************************************
  logic [15:0]       src_low;      // source start, low half
  logic [15:0]       src_high;     // source start, high half
  logic [15:0]       dst_low;      // destination start, low half
  logic [15:0]       dst_high;     // destination start, high half
  logic [15:0]       irq_count;    // compare count
  logic [15:0]       length;       // items minus one
  logic [CTRL_W-1:0] ctrl;         // control bits
  logic [ST_W-1:0]   status;       // sticky events
  logic [ST_W-1:0]   mask;         // event enables
  logic [3:0]        req_sel;      // selected request line
  logic [15:0]       item_index;   // items written so far
  logic [31:0]       data_hold;    // item between read and write
  dcci_state_type    state;        // sequencer state
  logic [WORD_W-1:0] word;         // decoded word index
  logic              bus_wr;       // write taking effect this edge
  logic              bus_rd;       // read being answered next edge
  logic [31:0]       next_dat;     // read mux
  logic [REQ_N-1:0]  req_sync;     // synchronised requests
  logic [15:0]       req_wide;     // requests padded to selector range
  logic              req_hit;      // selected request active
  logic [31:0]       src_addr;     // current source address
  logic [15:0]       src_index;    // index of the item read next
  logic [31:0]       dst_addr;     // current destination address
  logic              item_done;    // write of an item acknowledged
  logic              xfer_done;    // last item acknowledged
  logic              match;        // compare hit on this item
  logic              restart;      // circular restart on completion
  logic [ST_W-1:0]   ev_set;       // events raised this cycle

  // control field views
  logic       on;
  logic [1:0] width;
  logic       irq_en;
  logic       trig;
  assign on     = ctrl[CTRL_ON_BIT];
  assign width  = ctrl[CTRL_WIDTH_LSB +: 2];
  assign irq_en = ctrl[CTRL_IRQEN_BIT];
  assign trig   = ctrl[CTRL_TRIG_BIT];

  // *****************************************
  // submodules
  // *****************************************
  dcci_req_sync #(.REQ_N(REQ_N)) u_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .req_i (periph_req_i),
    .req_o (req_sync)
  );

  // next source address
  // the index register only advances at the write ack, so the read that
  // follows a write is addressed one item ahead to avoid refetching
  assign src_index = (state == ST_WRITE) ? 16'(item_index + 16'h0001) : item_index;

  dcci_addr_gen u_src (
    .start_i ({src_high, src_low}),
    .index_i (src_index),
    .width_i (width),
    .incr_i  (ctrl[CTRL_SINC_BIT]),
    .addr_o  (src_addr)
  );

  dcci_addr_gen u_dst (
    .start_i ({dst_high, dst_low}),
    .index_i (item_index),
    .width_i (width),
    .incr_i  (ctrl[CTRL_DINC_BIT]),
    .addr_o  (dst_addr)
  );

  // *****************************************
  // wishbone decode
  // *****************************************
  assign word   = adr_i[WORD_W+1:2];
  assign bus_wr = cyc_i && stb_i && we_i && ack_o;
  assign bus_rd = cyc_i && stb_i && !ack_o;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i && stb_i && !ack_o;
    end
  end

  // read mux; narrow registers sit in the low bits
  always_comb begin
    next_dat = 32'h00000000;
    unique case (word)
      IDX_ITEM_INDEX[WORD_W-1:0]: next_dat = {16'h0000, item_index};
      IDX_SRC_LOW[WORD_W-1:0]:    next_dat = {16'h0000, src_low};
      IDX_SRC_HIGH[WORD_W-1:0]:   next_dat = {16'h0000, src_high};
      IDX_DST_LOW[WORD_W-1:0]:    next_dat = {16'h0000, dst_low};
      IDX_DST_HIGH[WORD_W-1:0]:   next_dat = {16'h0000, dst_high};
      IDX_IRQ_COUNT[WORD_W-1:0]:  next_dat = {16'h0000, irq_count};
      IDX_LENGTH[WORD_W-1:0]:     next_dat = {16'h0000, length};
      IDX_CONTROL[WORD_W-1:0]:    next_dat = {24'h000000, ctrl};
      IDX_IRQ_STATUS[WORD_W-1:0]: next_dat = {30'h00000000, status};
      IDX_IRQ_MASK[WORD_W-1:0]:   next_dat = {30'h00000000, mask};
      IDX_REQ_SELECT[WORD_W-1:0]: next_dat = {28'h0000000, req_sel};
      // unmapped words read zero and ignore writes
      default:                    next_dat = 32'h00000000;
    endcase
  end

  // read data captured with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= 32'h00000000;
    end else if (bus_rd) begin
      dat_o <= next_dat;
    end
  end

  // *****************************************
  // configuration registers
  // *****************************************
  // halves written separately; low byte lanes carry the value
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_low   <= RST_HALF;
      src_high  <= RST_HALF;
      dst_low   <= RST_HALF;
      dst_high  <= RST_HALF;
      irq_count <= RST_HALF;
      length    <= RST_HALF;
      mask      <= '0;
      req_sel   <= 4'h0;
    end else if (bus_wr && sel_i[1:0] == 2'b11) begin
      unique case (word)
        IDX_SRC_LOW[WORD_W-1:0]:    src_low   <= dat_i[15:0];
        IDX_SRC_HIGH[WORD_W-1:0]:   src_high  <= dat_i[15:0];
        IDX_DST_LOW[WORD_W-1:0]:    dst_low   <= dat_i[15:0];
        IDX_DST_HIGH[WORD_W-1:0]:   dst_high  <= dat_i[15:0];
        IDX_IRQ_COUNT[WORD_W-1:0]:  irq_count <= dat_i[15:0];
        IDX_LENGTH[WORD_W-1:0]:     length    <= dat_i[15:0];
        IDX_IRQ_MASK[WORD_W-1:0]:   mask      <= dat_i[ST_W-1:0];
        IDX_REQ_SELECT[WORD_W-1:0]: req_sel   <= dat_i[3:0];
        // other words hold no writable state here
        default: ;
      endcase
    end
  end

  // control register; hardware clears the on bit at completion unless restart is set
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= RST_CTRL;
    end else if (bus_wr && sel_i[0] && word == IDX_CONTROL[WORD_W-1:0]) begin
      // a software write wins, so a restart written at the last item sticks
      ctrl <= dat_i[CTRL_W-1:0];
    end else if (xfer_done && !restart) begin
      ctrl[CTRL_ON_BIT] <= 1'b0;
    end
  end

  // *****************************************
  // request selection
  // *****************************************
  assign req_wide = 16'(req_sync);
  assign req_hit  = req_wide[req_sel];

  // *****************************************
  // sequencer
  // *****************************************
  assign item_done = (state == ST_WRITE) && mem_ack_i;
  // last item is index equal to length
  assign xfer_done = item_done && (item_index == length);
  // circular only counts with peripheral triggering
  assign restart   = ctrl[CTRL_CIRC_BIT] && trig;
  assign match     = item_done && (irq_count == item_index);

  // state and bus master outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state       <= ST_IDLE;
      mem_we_o    <= 1'b0;
      mem_addr_o  <= 32'h00000000;
      mem_wdata_o <= 32'h00000000;
      data_hold   <= 32'h00000000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          // nothing moves while the channel is off
          if (on) begin
            if (!trig) begin
              state      <= ST_READ;
              mem_we_o   <= 1'b0;
              mem_addr_o <= src_addr;
            end else begin
              state <= ST_WAIT_REQ;
            end
          end
        end
        ST_WAIT_REQ: begin
          if (!on) begin
            state <= ST_IDLE;
          end else if (req_hit) begin
            state      <= ST_READ;
            mem_we_o   <= 1'b0;
            mem_addr_o <= src_addr;
          end
        end
        ST_READ: begin
          if (mem_ack_i) begin
            state       <= ST_WRITE;
            data_hold   <= mem_rdata_i;
            mem_wdata_o <= mem_rdata_i;
            mem_we_o    <= 1'b1;
            mem_addr_o  <= dst_addr;
          end
        end
        ST_WRITE: begin
          if (mem_ack_i) begin
            mem_we_o <= 1'b0;
            // a software stop between items ends the run cleanly
            if ((xfer_done && !restart) || !on) begin
              state <= ST_IDLE;
            end else if (trig) begin
              state <= ST_WAIT_REQ;
            end else begin
              state      <= ST_READ;
              mem_addr_o <= src_addr;
            end
          end
        end
      endcase
    end
  end

  // bus request stands through the read and the write phase
  assign mem_cyc_o  = (state == ST_READ) || (state == ST_WRITE);
  // size code, reserved treated as byte
  assign mem_size_o = (width == WIDTH_RSVD) ? WIDTH_BYTE : width;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      item_index <= 16'h0000;
    end else if (xfer_done) begin
      item_index <= 16'h0000;
    end else if (item_done) begin
      item_index <= 16'(item_index + 16'h0001);
    end
  end

  // *****************************************
  // interrupt
  // *****************************************
  // count match only with interrupt enabled
  assign ev_set[ST_MATCH_BIT] = match && irq_en;
  assign ev_set[ST_DONE_BIT]  = xfer_done;

  // sticky flags, write one to clear; a new event beats the clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= '0;
    end else if (bus_wr && sel_i[0] && word == IDX_IRQ_STATUS[WORD_W-1:0]) begin
      status <= (status & ~dat_i[ST_W-1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  assign irq_o = |(status & mask);

  // *****************************************
  // assertions
  // *****************************************
  sequence seq_item_done;
    state == ST_WRITE && mem_ack_i;
  endsequence

  sequence seq_last_item;
    seq_item_done ##0 (item_index == length);
  endsequence

  AST_IMMEDIATE_START: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && on && !trig |=> state == ST_READ && mem_addr_o == $past(src_addr))
    else $error("mode 0 did not start at once");

  AST_WAIT_TRIGGER: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_WAIT_REQ && !req_hit |=> state != ST_READ)
    else $error("read started without request");

  AST_IRQ_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(status[ST_MATCH_BIT]) |-> $past(irq_en) && $past(match))
    else $error("match flag set without enable");

  AST_SIZE_CODE: assert property (@(posedge clk_i) disable iff (rst_i)
    mem_cyc_o |-> mem_size_o == ((width == WIDTH_RSVD) ? WIDTH_BYTE : width))
    else $error("bus size disagrees with width");

  AST_OFF_STILL: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_IDLE && !on |=> !mem_cyc_o)
    else $error("channel active while off");

  AST_ON_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_last_item ##0 !restart ##0 !bus_wr |=> !on && state == ST_IDLE)
    else $error("on bit not cleared at completion");

  AST_INDEX_RO: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && !item_done |=> $stable(item_index))
    else $error("index changed by software");

  AST_INDEX_ZERO: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_last_item |=> item_index == 16'h0000)
    else $error("index not cleared at completion");

  AST_WRITE_ADDR: assert property (@(posedge clk_i) disable iff (rst_i)
    state == ST_READ && mem_ack_i |=> mem_addr_o == $past(dst_addr) && mem_we_o)
    else $error("destination address wrong");

  AST_SRC_LOW: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && sel_i[1:0] == 2'b11 && word == IDX_SRC_LOW[WORD_W-1:0] |=> src_low == $past(dat_i[15:0]))
    else $error("source low half not written");

  AST_DST_HIGH: assert property (@(posedge clk_i) disable iff (rst_i)
    bus_wr && sel_i[1:0] == 2'b11 && word == IDX_DST_HIGH[WORD_W-1:0] |=> dst_high == $past(dat_i[15:0]))
    else $error("destination high half not written");

  AST_MATCH_IRQ: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_item_done ##0 (irq_count == item_index && irq_en) |=> status[ST_MATCH_BIT])
    else $error("count match did not raise flag");

  AST_LENGTH: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_item_done ##0 (item_index != length) |=> item_index == 16'($past(item_index) + 16'h0001))
    else $error("index stepped wrongly before last item");

  AST_CIRCULAR: assert property (@(posedge clk_i) disable iff (rst_i)
    seq_last_item ##0 restart ##0 !bus_wr |=> on && state == ST_WAIT_REQ && item_index == 16'h0000)
    else $error("circular restart failed");

endmodule

/* File: tb/dcci_mem_model.sv */
// system bus partner model: answers data moves and logs every store
`timescale 1ns/100ps
module dcci_mem_model (
  // clock
  input  wire logic        clk_i,
  // data bus from the channel
  input  wire logic        mem_cyc_i,
  input  wire logic        mem_we_i,
  input  wire logic [31:0] mem_addr_i,
  input  wire logic [1:0]  mem_size_i,
  input  wire logic [31:0] mem_wdata_i,
  output logic      [31:0] mem_rdata_o,
  output logic             mem_ack_o
);
  logic [65:0] wr_q[$]; // logged stores: size, address, data
  int          wait_n;  // cycles left before answering
  initial begin
    mem_ack_o   = 1'b0;
    mem_rdata_o = 32'h0;
    wait_n      = 0;
  end
  // random delay; ack lasts one cycle so no request is taken twice
  always @(posedge clk_i) begin
    if (mem_ack_o || !mem_cyc_i) begin
      mem_ack_o   <= 1'b0;
      mem_rdata_o <= ~mem_rdata_o; // no stale data outside an answer
      wait_n      <= $urandom_range(3);
    end else if (wait_n > 0) begin
      wait_n      <= wait_n - 1;
      mem_rdata_o <= ~mem_rdata_o;
    end else begin
      mem_ack_o   <= 1'b1;
      mem_rdata_o <= mem_addr_i ^ 32'hA5A55A5A;
      if (mem_we_i) wr_q.push_back({mem_size_i, mem_addr_i, mem_wdata_i});
    end
  end
endmodule

/* File: tb/dma_channel_control_index_tb_top.sv */
// self-checking bench for the dma channel control and index block
`timescale 1ns/100ps
module dma_channel_control_index_tb_top
  import dcci_pkg::*;
;
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, ack, irq, mem_cyc, mem_we, mem_ack;
  logic [7:0] adr = 0;
  logic [3:0] sel = 0;
  logic [15:0] req = 0;
  logic [1:0] mem_size;
  logic [31:0] dat_w = 0, dat_r, mem_addr, mem_wdata, mem_rdata, q;
  logic [15:0] v;
  int mismatches = 0, checked = 0;
  always #25 clk = ~clk;
  dcci_channel #(.REQ_N(16)) dcci_channel_i (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat_w), .dat_o(dat_r), .ack_o(ack), .periph_req_i(req), .mem_cyc_o(mem_cyc),
    .mem_we_o(mem_we), .mem_addr_o(mem_addr), .mem_size_o(mem_size), .mem_wdata_o(mem_wdata),
    .mem_rdata_i(mem_rdata), .mem_ack_i(mem_ack), .irq_o(irq));
  dcci_mem_model dcci_mem_model_i (.clk_i(clk), .mem_cyc_i(mem_cyc), .mem_we_i(mem_we), .mem_addr_i(mem_addr),
    .mem_size_i(mem_size), .mem_wdata_i(mem_wdata), .mem_rdata_o(mem_rdata), .mem_ack_o(mem_ack));
  // one comparison, counted and reported
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // classic wishbone single cycle; data taken at the ack edge only
  task automatic wb(input logic w, input logic [31:0] idx, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk);
    {cyc, stb, we, sel} <= {2'b11, w, 4'hF};
    adr <= {idx[5:0], 2'b00};
    dat_w <= d;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    r = dat_r;
    {cyc, stb} <= 2'b00;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask
  // verdict in one place
  task automatic test_done();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // program start halves, length and control, then poll until the on bit drops
  task automatic xfer(input logic [1:0] w, input logic si, di, ie, input logic [15:0] n);
    logic [31:0] s, d, st, ck;
    int k;
    s = $urandom;
    d = $urandom;
    st = (w == 2'h3) ? 1 : (1 << w);
    k = 0;
    dcci_mem_model_i.wr_q.delete();
    wb(1, IDX_SRC_LOW, s[15:0], q);
    wb(1, IDX_SRC_HIGH, s[31:16], q);
    wb(1, IDX_DST_LOW, d[15:0], q);
    wb(1, IDX_DST_HIGH, d[31:16], q);
    wb(1, IDX_LENGTH, n, q);
    wb(1, IDX_IRQ_COUNT, $urandom_range(n), q);
    wb(1, IDX_CONTROL, {25'h0, si, di, 1'b0, ie, w, 1'b1}, q);
    do begin
      wb(0, IDX_CONTROL, 0, q);
      k++;
    end while (q[0] !== 1'b0 && k < 100);
    chk(q[0], 1'b0); // on bit self-clears
    wb(0, IDX_ITEM_INDEX, 0, q);
    chk(q, 0); // index back to zero
    chk(dcci_mem_model_i.wr_q.size(), n + 1); // N+1 items
    for (int i = 0; i <= n && i < dcci_mem_model_i.wr_q.size(); i++) begin
      ck = s + (si ? i * st : 0);
      chk(dcci_mem_model_i.wr_q[i][65:64], (w == 2'h3) ? 2'h0 : w); // item width
      chk(dcci_mem_model_i.wr_q[i][63:32], d + (di ? i * st : 0)); // destination step
      chk(dcci_mem_model_i.wr_q[i][31:0], ck ^ 32'hA5A55A5A); // source step
    end
    wb(0, IDX_IRQ_STATUS, 0, q);
    chk(q, {30'h0, 1'b1, ie}); // match only when enabled
    chk(irq, ie); // interrupt output
    wb(1, IDX_IRQ_STATUS, 32'h3, q);
    @(posedge clk);
    chk(irq, 1'b0); // write one clears the interrupt
  endtask
  initial begin
    #(50 * 60000);
    mismatches++;
    test_done();
  end
  initial begin
    void'($urandom(3750));
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) begin
      wb(0, IDX_ITEM_INDEX + 2 * i, 0, q);
      chk(q, 0); // reset values
    end
    wb(0, 32'h0, 0, q);
    chk(q, 0); // unmapped word reads zero
    wb(1, IDX_ITEM_INDEX, 32'hFFFF, q);
    wb(0, IDX_ITEM_INDEX, 0, q);
    chk(q, 0); // index is read only
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom);
      wb(1, IDX_SRC_LOW + 2 * i, v, q);
      wb(0, IDX_SRC_LOW + 2 * i, 0, q);
      chk(q, v); // halves read back
    end
    wb(1, IDX_CONTROL, 32'h0000007E, q);
    repeat (20) @(posedge clk);
    chk(mem_cyc, 1'b0); // channel off stays inactive
    wb(1, IDX_IRQ_MASK, 32'h1, q);
    for (int i = 0; i < 8; i++) xfer(i[1:0], 1'($urandom), 1'($urandom), i[2], 16'($urandom_range(3))); // all codes
    dcci_mem_model_i.wr_q.delete();
    wb(1, IDX_REQ_SELECT, 32'h5, q);
    wb(1, IDX_LENGTH, 32'h2, q);
    wb(1, IDX_CONTROL, 32'h000000F5, q);
    req <= 16'hFFDF & 16'($urandom);
    repeat (30) @(posedge clk);
    chk(dcci_mem_model_i.wr_q.size(), 0); // waits for selected request
    req[5] <= 1'b1;
    for (int k = 0; k < 300 && dcci_mem_model_i.wr_q.size() < 5; k++) @(posedge clk);
    req <= 16'h0;
    chk(dcci_mem_model_i.wr_q.size() >= 5, 1'b1); // transfer goes on past the last item
    chk(dcci_mem_model_i.wr_q[3][63:32], dcci_mem_model_i.wr_q[0][63:32]); // index wraps
    chk(dcci_mem_model_i.wr_q[4][63:32], dcci_mem_model_i.wr_q[1][63:32]); // restarts
    wb(0, IDX_CONTROL, 0, q);
    chk(q[0], 1'b1); // stays on in circular mode
    wb(1, IDX_CONTROL, 32'h0, q);
    repeat (20) @(posedge clk);
    chk(mem_cyc, 1'b0); // off halts the channel
    test_done();
  end
endmodule
